/* File: rtl/tdf_consts.svh */
`ifndef TDF_CONSTS_SVH
`define TDF_CONSTS_SVH
// debug data register selects
`define TDF_SEL_PART_ID      8'h00
`define TDF_SEL_REV_ID       8'h01
`define TDF_SEL_PROG_CTRL    8'h02
`define TDF_SEL_PROG_DATA    8'hBF
`define TDF_SEL_PROG_DATA_B  8'hB4
// unlock codes
`define TDF_UNLOCK_FIRST     8'h02
`define TDF_UNLOCK_SECOND    8'h01
// flash command codes
`define TDF_CMD_BLOCK_READ   8'h06
`define TDF_CMD_BLOCK_WRITE  8'h07
`define TDF_CMD_DEVICE_ERASE 8'h03
`define TDF_CMD_PAGE_ERASE   8'h08
// reset values
`define TDF_RST_CTRL         8'h00
`define TDF_RST_DATA         8'h00
`define TDF_RST_SELECT       8'h00
// status byte fields
`define TDF_ST_BUSY_BIT      0
`define TDF_ST_BAD_BIT       1
`define TDF_ST_UNLOCK_BIT    7
// timing
`define TDF_CLK_NS           100
`define TDF_LINK_RESET_NS    20000
`define TDF_LINK_RESET_CYC   ((`TDF_LINK_RESET_NS) / (`TDF_CLK_NS))
`endif

/* File: rtl/tdf_pkg.sv */
package tdf_pkg;
   typedef enum logic [1:0] {
      TDF_INS_DATA_READ,
      TDF_INS_ADDR_WRITE,
      TDF_INS_DATA_WRITE,
      TDF_INS_ADDR_READ
   } tdf_ins_type;
   typedef enum {
      TDF_LINK_IDLE,
      TDF_LINK_INS,
      TDF_LINK_WDATA,
      TDF_LINK_RDATA
   } tdf_link_type;
   typedef enum {
      TDF_LOCKED,
      TDF_HALF_OPEN,
      TDF_UNLOCKED
   } tdf_lock_type;
endpackage : tdf_pkg

/* File: rtl/tdf_debug_port.sv */
// How it works
// - the select register routes data reads and writes to id, control or data
// - part identifier is read-only and returns a fixed 8-bit type code
// - revision identifier is read-only and tells first from second silicon
// - flash commands accepted only after control gets 0x02 then 0x01
// - data register carries commands 0x06, 0x07, 0x03, 0x08, addresses, data
// - core is held halted while debug programming owns the pins
// - host clock line plus one shared two-way data line
// - on first silicon the link works only while the port latch holds 1
// - idle pin is open drain, mode bit 0 and latch 1
`timescale 1ns/100ps
`default_nettype none
`include "tdf_consts.svh"

// ----------------------------------------
// command fifo
// ----------------------------------------
module tdf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ff;
   logic [AW:0]      rd_ff;
   wire              push = in_valid_in && in_ready_out;
   wire              pop  = out_valid_out && out_ready_in;
   assign in_ready_out  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_ff != rd_ff;
   assign out_data_out  = mem_ff[rd_ff[AW-1:0]];
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= in_data_in;
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= wr_ff + (AW+1)'(push);
         rd_ff <= rd_ff + (AW+1)'(pop);
      end
   end
endmodule : tdf_fifo

// ----------------------------------------
// debug port
// ----------------------------------------
module tdf_debug_port #(
   parameter logic [7:0] PART_ID      = 8'h5A, // arbitrary value
   parameter logic [7:0] REV_ID       = 8'h0A, // arbitrary value
   parameter logic [7:0] FIRST_REV_ID = 8'h0A, // arbitrary value
   parameter int         FIFO_DEPTH   = 32
) (
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       debug_link_clock_line_in,
   input  wire logic       debug_link_data_line_in,
   output logic            debug_link_data_line_out,
   output logic            debug_link_data_line_oe_out,
   input  wire logic       port_latch_in,
   input  wire logic       port_output_mode_bit_in,
   output logic            core_halt_out,
   output logic            flash_valid_out,
   input  wire logic       flash_ready_in,
   output logic [7:0]      flash_byte_out,
   output logic            flash_first_out,
   input  wire logic       flash_done_in,
   input  wire logic       flash_rd_valid_in,
   input  wire logic [7:0] flash_rd_data_in,
   output logic            link_busy_out
);
   if (FIFO_DEPTH < 2) $error("fifo too shallow");

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] ck_sync_ff;
   logic [1:0] d_sync_ff;
   logic [1:0] latch_sync_ff;
   logic       ck_prev_ff;
   always_ff @(posedge clock_in) begin
      ck_sync_ff    <= {ck_sync_ff[0], debug_link_clock_line_in};
      d_sync_ff     <= {d_sync_ff[0], debug_link_data_line_in};
      latch_sync_ff <= {latch_sync_ff[0], port_latch_in};
      ck_prev_ff    <= ck_sync_ff[1];
   end
   wire ck_rise = ck_sync_ff[1] && !ck_prev_ff;
   wire ck_fall = !ck_sync_ff[1] && ck_prev_ff;
   wire din     = d_sync_ff[1];

   // the clock pin doubles as reset: a long low aborts any frame
   localparam int RST_CYC = `TDF_LINK_RESET_CYC;
   logic [$clog2(RST_CYC+1)-1:0] low_cnt_ff;
   wire link_abort = low_cnt_ff == ($clog2(RST_CYC+1))'(RST_CYC);
   // first silicon loses the link whenever the latch pulls the pin low
   wire latch_block = (REV_ID == FIRST_REV_ID) && !latch_sync_ff[1];
   always_ff @(posedge clock_in) begin
      if (rst_in || ck_sync_ff[1]) begin
         low_cnt_ff <= '0;
      end else if (!link_abort) begin
         low_cnt_ff <= low_cnt_ff + 1'b1;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]        select_ff;
   logic [7:0]        ctrl_ff;
   logic [7:0]        rd_data_ff;
   tdf_pkg::tdf_lock_type lock_ff;
   logic              cmd_phase_ff;
   logic              bad_ff;
   logic              fifo_ready;
   wire unlocked = lock_ff == tdf_pkg::TDF_UNLOCKED;
   wire sel_data = select_ff == `TDF_SEL_PROG_DATA || select_ff == `TDF_SEL_PROG_DATA_B;

   function automatic logic good_cmd(input logic [7:0] b);
      good_cmd = b == `TDF_CMD_BLOCK_READ || b == `TDF_CMD_BLOCK_WRITE ||
                 b == `TDF_CMD_DEVICE_ERASE || b == `TDF_CMD_PAGE_ERASE;
   endfunction : good_cmd

   wire [7:0] status = {unlocked, 5'h00, bad_ff, !fifo_ready};
   wire [7:0] read_mux =
      (select_ff == `TDF_SEL_PART_ID)   ? PART_ID :
      (select_ff == `TDF_SEL_REV_ID)    ? REV_ID :
      (select_ff == `TDF_SEL_PROG_CTRL) ? ctrl_ff :
      sel_data                          ? rd_data_ff : 8'h00;

   // ----------------------------------------
   // link frame
   // ----------------------------------------
   tdf_pkg::tdf_link_type state_ff;
   tdf_pkg::tdf_ins_type  ins_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic       drive_ff;
   logic       dout_ff;
   wire last_ins  = state_ff == tdf_pkg::TDF_LINK_INS && ck_rise && cnt_ff == 4'h1;
   wire [1:0] ins_code = {din, ins_ff[0]};
   wire wr_done   = state_ff == tdf_pkg::TDF_LINK_WDATA && ck_rise && cnt_ff == 4'h7;
   wire [7:0] wbyte = {din, shift_ff[7:1]};
   wire wr_addr   = wr_done && ins_ff == tdf_pkg::TDF_INS_ADDR_WRITE;
   wire wr_data   = wr_done && ins_ff == tdf_pkg::TDF_INS_DATA_WRITE;
   wire wr_ctrl   = wr_data && select_ff == `TDF_SEL_PROG_CTRL;
   wire wr_prog   = wr_data && sel_data && unlocked;
   wire push_ok   = wr_prog && (!cmd_phase_ff || good_cmd(wbyte));
   wire fifo_in_valid = push_ok && fifo_ready;

   always_ff @(posedge clock_in) begin
      if (rst_in || link_abort || latch_block) begin
         state_ff <= tdf_pkg::TDF_LINK_IDLE;
         drive_ff <= 1'b0;
         dout_ff  <= 1'b1;
         cnt_ff   <= 4'h0;
         ins_ff   <= tdf_pkg::TDF_INS_DATA_READ;
         shift_ff <= 8'h00;
      end else begin
         case (state_ff)
            tdf_pkg::TDF_LINK_IDLE: begin
               if (ck_rise && !din) begin
                  state_ff <= tdf_pkg::TDF_LINK_INS;
                  cnt_ff   <= 4'h0;
               end
            end
            tdf_pkg::TDF_LINK_INS: begin
               if (ck_rise) begin
                  ins_ff <= tdf_pkg::tdf_ins_type'(cnt_ff == 4'h0 ? {1'b0, din} : ins_code);
                  cnt_ff <= cnt_ff + 4'h1;
                  if (last_ins) begin
                     cnt_ff <= 4'h0;
                     if (ins_code == 2'b00 || ins_code == 2'b11) begin
                        state_ff <= tdf_pkg::TDF_LINK_RDATA;
                        shift_ff <= ins_code == 2'b11 ? status : read_mux;
                     end else begin
                        state_ff <= tdf_pkg::TDF_LINK_WDATA;
                     end
                  end
               end
            end
            tdf_pkg::TDF_LINK_WDATA: begin
               if (ck_rise) begin
                  shift_ff <= wbyte;
                  cnt_ff   <= cnt_ff + 4'h1;
                  if (wr_done) begin
                     state_ff <= tdf_pkg::TDF_LINK_IDLE;
                  end
               end
            end
            tdf_pkg::TDF_LINK_RDATA: begin
               // device changes data on falls, host samples on rises
               if (ck_fall) begin
                  if (cnt_ff == 4'h8) begin
                     drive_ff <= 1'b0;
                     state_ff <= tdf_pkg::TDF_LINK_IDLE;
                  end else begin
                     drive_ff <= 1'b1;
                     dout_ff  <= shift_ff[0];
                     shift_ff <= {1'b0, shift_ff[7:1]};
                     cnt_ff   <= cnt_ff + 4'h1;
                  end
               end
            end
            default: state_ff <= tdf_pkg::TDF_LINK_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // register updates
   // ----------------------------------------
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         select_ff <= `TDF_RST_SELECT;
      end else if (wr_addr) begin
         select_ff <= wbyte;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_ff <= `TDF_RST_CTRL;
         lock_ff <= tdf_pkg::TDF_LOCKED;
      end else if (wr_ctrl) begin
         ctrl_ff <= wbyte;
         // before unlock, any out-of-order code drops back to locked; once unlocked it holds until reset
         if (wbyte == `TDF_UNLOCK_FIRST && lock_ff != tdf_pkg::TDF_UNLOCKED) begin
            lock_ff <= tdf_pkg::TDF_HALF_OPEN;
         end else if (wbyte == `TDF_UNLOCK_SECOND && lock_ff == tdf_pkg::TDF_HALF_OPEN) begin
            lock_ff <= tdf_pkg::TDF_UNLOCKED;
         end else if (lock_ff != tdf_pkg::TDF_UNLOCKED) begin
            lock_ff <= tdf_pkg::TDF_LOCKED;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cmd_phase_ff <= 1'b1;
         bad_ff       <= 1'b0;
         rd_data_ff   <= `TDF_RST_DATA;
      end else begin
         if (fifo_in_valid && cmd_phase_ff) begin
            cmd_phase_ff <= 1'b0;
         end else if (flash_done_in) begin
            cmd_phase_ff <= 1'b1;
         end
         // set wins over the clear by a control write
         if (wr_prog && cmd_phase_ff && !good_cmd(wbyte)) begin
            bad_ff <= 1'b1;
         end else if (wr_ctrl) begin
            bad_ff <= 1'b0;
         end
         if (flash_rd_valid_in) begin
            rd_data_ff <= flash_rd_data_in;
         end
      end
   end

   tdf_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) cmd_fifo (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .in_valid_in   (fifo_in_valid),
      .in_ready_out  (fifo_ready),
      .in_data_in    ({cmd_phase_ff, wbyte}),
      .out_valid_out (flash_valid_out),
      .out_ready_in  (flash_ready_in),
      .out_data_out  ({flash_first_out, flash_byte_out})
   );

   // ----------------------------------------
   // pin and core outputs
   // ----------------------------------------
   // debug drive wins; otherwise the user port: open drain when mode bit is 0
   wire user_oe = port_output_mode_bit_in || !port_latch_in;
   assign debug_link_data_line_oe_out = drive_ff || user_oe;
   assign debug_link_data_line_out    = drive_ff ? dout_ff : port_latch_in;
   assign core_halt_out = unlocked;
   assign link_busy_out = !fifo_ready;
endmodule : tdf_debug_port
`default_nettype wire

/* File: sim/tdf_debug_port_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module tdf_debug_port_properties (
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       debug_link_clock_line_in,
   input wire logic       debug_link_data_line_out,
   input wire logic       debug_link_data_line_oe_out,
   input wire logic       port_latch_in,
   input wire logic       port_output_mode_bit_in,
   input wire logic       core_halt_out,
   input wire logic       flash_valid_out,
   input wire logic       flash_ready_in,
   input wire logic [7:0] flash_byte_out,
   input wire logic       flash_first_out,
   input wire logic       link_busy_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic [4:0] high_ff;
   logic [4:0] nxt_high;
   // saturates so a long idle never wraps back to zero
   assign nxt_high = !debug_link_clock_line_in ? 5'h00 : high_ff + {4'h0, high_ff != 5'h1F};
   always_ff @(posedge clock_in) high_ff <= rst_in ? 5'h00 : nxt_high;
   property p_hold;
      flash_valid_out && !flash_ready_in |=> flash_valid_out && $stable(flash_byte_out)
         && $stable(flash_first_out);
   endproperty
   property p_locked;
      !core_halt_out |-> !flash_valid_out;
   endproperty
   property p_halt;
      core_halt_out |=> core_halt_out;
   endproperty
   property p_idle;
      high_ff > 5'h0B && port_latch_in && !port_output_mode_bit_in |-> !debug_link_data_line_oe_out;
   endproperty
   property p_user_low;
      (!port_latch_in) [*4] |-> debug_link_data_line_oe_out && !debug_link_data_line_out;
   endproperty
   property p_busy;
      link_busy_out |-> flash_valid_out;
   endproperty
   property p_first;
      flash_valid_out && flash_first_out |-> flash_byte_out inside {8'h06, 8'h07, 8'h03, 8'h08};
   endproperty
   property p_reset;
      $fell(rst_in) |-> !core_halt_out && !flash_valid_out && !link_busy_out;
   endproperty
   a_hold: assert property (p_hold) else $error("flash word moved before taken");
   a_locked: assert property (p_locked) else $error("flash word while locked");
   a_halt: assert property (p_halt) else $error("halt dropped without reset");
   a_idle: assert property (p_idle) else $error("data pin driven while idle");
   a_user_low: assert property (p_user_low) else $error("low latch not on pin");
   a_busy: assert property (p_busy) else $error("full buffer shows no word");
   a_first: assert property (p_first) else $error("bad command passed on");
   a_reset: assert property (p_reset) else $error("outputs not quiet at reset");
   c_busy: cover property (link_busy_out);
   c_cmd: cover property (flash_valid_out && flash_ready_in && flash_first_out);
   c_open: cover property ($rose(core_halt_out));
endmodule : tdf_debug_port_properties
`default_nettype wire

/* File: sim/tdf_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tdf_consts.svh"
// ----------------------------------------
// host adapter
// ----------------------------------------
module tdf_host_model (
   input  wire logic clock_in,
   input  wire logic wire_in,
   output logic      link_clk_out,
   output logic      host_oe_out,
   output logic      host_data_out
);
   initial begin
      link_clk_out = 1'b1;
      host_oe_out = 1'b0;
      host_data_out = 1'b1;
   end
   task automatic half(input logic v);
      repeat (4) @(posedge clock_in);
      #1 link_clk_out = v;
   endtask : half
   task automatic send(input logic b);
      half(1'b0);
      host_oe_out = 1'b1;
      host_data_out = b;
      half(1'b1);
   endtask : send
   task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
      send(1'b0);
      send(ins[0]);
      send(ins[1]);
      rd = 8'h00;
      if (ins == 2'b01 || ins == 2'b10) begin
         for (int i = 0; i < 8; i++) send(wd[i]);
      end else begin
         for (int i = 0; i < 8; i++) begin
            half(1'b0);
            // wire handed over only once the last instruction bit was taken
            if (i == 0) host_oe_out = 1'b0;
            half(1'b1);
            // bit stands to the next fall, so sample late for margin
            repeat (3) @(posedge clock_in);
            rd[i] = wire_in;
         end
         half(1'b0);
         half(1'b1);
      end
      // device samples three cycles after a rise, so hold the last bit past that
      repeat (4) @(posedge clock_in);
      #1 host_oe_out = 1'b0;
      // clock stands high between frames
      repeat (16) @(posedge clock_in);
   endtask : frame
   task automatic cut;
      send(1'b0);
      send(1'b1);
      send(1'b0);
      half(1'b0);
      host_oe_out = 1'b0;
      // clock held low past the link reset count drops the half-done frame
      repeat (`TDF_LINK_RESET_CYC + 8) @(posedge clock_in);
      #1 link_clk_out = 1'b1;
      repeat (16) @(posedge clock_in);
   endtask : cut
endmodule : tdf_host_model
`default_nettype wire

/* File: sim/tdf_testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tdf_consts.svh"
module testbench;
   logic clock_in = 1'b0, rst_in = 1'b1, port_latch_in = 1'b1, port_output_mode_bit_in = 1'b0;
   logic flash_ready_in = 1'b0, flash_done_in = 1'b0, flash_rd_valid_in = 1'b0;
   logic [7:0] flash_rd_data_in = 8'h00, flash_byte_out;
   logic debug_link_clock_line_in, debug_link_data_line_in, debug_link_data_line_out;
   logic debug_link_data_line_oe_out, core_halt_out, flash_valid_out, flash_first_out;
   logic link_busy_out, host_oe, host_d;
   logic [8:0] got[$];
   int mismatches = 0, tests_run = 0;
   localparam logic [1:0] RD = tdf_pkg::TDF_INS_DATA_READ, AW = tdf_pkg::TDF_INS_ADDR_WRITE;
   localparam logic [1:0] DW = tdf_pkg::TDF_INS_DATA_WRITE, ST = tdf_pkg::TDF_INS_ADDR_READ;
   // open-drain wire with pull-up
   assign debug_link_data_line_in = !((debug_link_data_line_oe_out && !debug_link_data_line_out)
      || (host_oe && !host_d));
   always #50 clock_in = !clock_in;
   tdf_debug_port uut (
      .clock_in                    (clock_in),
      .rst_in                      (rst_in),
      .debug_link_clock_line_in    (debug_link_clock_line_in),
      .debug_link_data_line_in     (debug_link_data_line_in),
      .debug_link_data_line_out    (debug_link_data_line_out),
      .debug_link_data_line_oe_out (debug_link_data_line_oe_out),
      .port_latch_in               (port_latch_in),
      .port_output_mode_bit_in     (port_output_mode_bit_in),
      .core_halt_out               (core_halt_out),
      .flash_valid_out             (flash_valid_out),
      .flash_ready_in              (flash_ready_in),
      .flash_byte_out              (flash_byte_out),
      .flash_first_out             (flash_first_out),
      .flash_done_in               (flash_done_in),
      .flash_rd_valid_in           (flash_rd_valid_in),
      .flash_rd_data_in            (flash_rd_data_in),
      .link_busy_out               (link_busy_out)
   );
   tdf_host_model host (.clock_in(clock_in), .wire_in(debug_link_data_line_in),
      .link_clk_out(debug_link_clock_line_in), .host_oe_out(host_oe), .host_data_out(host_d));
   always @(posedge clock_in) if (flash_valid_out === 1'b1 && flash_ready_in === 1'b1)
      got.push_back({flash_first_out, flash_byte_out});
   task automatic end_sim;
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [1:0] ins, input logic [7:0] exp);
      logic [7:0] v;
      host.frame(ins, 8'h00, v);
      check({1'b0, v}, {1'b0, exp});
   endtask : rd
   task automatic wr(input logic [1:0] ins, input logic [7:0] d);
      logic [7:0] v;
      host.frame(ins, d, v);
   endtask : wr
   task automatic pulse_done;
      @(posedge clock_in) #1 flash_done_in = 1'b1;
      @(posedge clock_in) #1 flash_done_in = 1'b0;
   endtask : pulse_done
   task automatic t_reset;
      @(posedge clock_in) #1 rst_in = 1'b1;
      repeat (20) @(posedge clock_in);
      #1 rst_in = 1'b0;
      repeat (4) @(posedge clock_in);
      rd(RD, 8'h5A);
      rd(ST, 8'h00);
      check({8'h00, core_halt_out}, 9'h000);
   endtask : t_reset
   task automatic t_ids;
      host.cut();
      wr(AW, `TDF_SEL_REV_ID);
      rd(RD, 8'h0A);
      wr(DW, 8'h55);
      rd(RD, 8'h0A);
      wr(AW, `TDF_SEL_PART_ID);
      wr(DW, 8'h55);
      rd(RD, 8'h5A);
   endtask : t_ids
   task automatic t_unlock;
      wr(AW, `TDF_SEL_PROG_DATA);
      wr(DW, `TDF_CMD_BLOCK_READ);
      check({8'h00, flash_valid_out}, 9'h000);
      wr(AW, `TDF_SEL_PROG_CTRL);
      wr(DW, `TDF_UNLOCK_SECOND);
      wr(DW, `TDF_UNLOCK_FIRST);
      rd(ST, 8'h00);
      wr(DW, `TDF_UNLOCK_SECOND);
      rd(ST, 8'h80);
      rd(RD, `TDF_UNLOCK_SECOND);
      check({8'h00, core_halt_out}, 9'h001);
   endtask : t_unlock
   task automatic t_cmds;
      logic [7:0] c[4] = '{8'h06, 8'h07, 8'h03, 8'h08};
      #1 flash_ready_in = 1'b1;
      wr(AW, `TDF_SEL_PROG_DATA_B);
      wr(DW, 8'h55);
      rd(ST, 8'h82);
      for (int k = 0; k < 4; k++) begin
         wr(DW, c[k]);
         wr(DW, 8'hA5);
         pulse_done();
      end
      check({1'b0, got.size() == 8}, 9'h001);
      for (int k = 0; k < 4; k++) check(got[2 * k], {1'b1, c[k]});
      for (int k = 0; k < 4; k++) check(got[2 * k + 1], 9'h0A5);
   endtask : t_cmds
   task automatic t_fill;
      int n;
      got.delete();
      @(posedge clock_in) #1 flash_ready_in = 1'b0;
      wr(DW, `TDF_CMD_BLOCK_WRITE);
      for (int i = 1; i < 32; i++) wr(DW, 8'(i));
      check({8'h00, link_busy_out}, 9'h001);
      wr(DW, 8'hEE);
      rd(ST, 8'h83);
      @(posedge clock_in) #1 flash_ready_in = 1'b1;
      for (n = 0; n < 200 && got.size() < 32; n++) @(posedge clock_in);
      if (n == 200) begin
         mismatches++;
         end_sim();
      end
      check({8'h00, link_busy_out}, 9'h000);
      check(got[0], 9'h107);
      for (int i = 1; i < 32; i++) check(got[i], 9'(i));
      pulse_done();
   endtask : t_fill
   task automatic t_rdata;
      @(posedge clock_in) #1 flash_rd_valid_in = 1'b1;
      flash_rd_data_in = 8'hC3;
      @(posedge clock_in) #1 flash_rd_valid_in = 1'b0;
      rd(RD, 8'hC3);
      wr(AW, `TDF_SEL_PROG_DATA);
      rd(RD, 8'hC3);
   endtask : t_rdata
   task automatic t_latch;
      wr(AW, `TDF_SEL_PART_ID);
      #1 port_latch_in = 1'b0;
      rd(RD, 8'h00);
      #1 port_latch_in = 1'b1;
      rd(RD, 8'h5A);
      #1 port_output_mode_bit_in = 1'b1;
      repeat (3) @(posedge clock_in);
      check({7'h00, debug_link_data_line_oe_out, debug_link_data_line_out}, 9'h003);
      #1 port_output_mode_bit_in = 1'b0;
      repeat (3) @(posedge clock_in);
      check({8'h00, debug_link_data_line_oe_out}, 9'h000);
   endtask : t_latch
   initial begin
      t_reset();
      t_ids();
      t_unlock();
      t_cmds();
      t_fill();
      t_rdata();
      t_latch();
      t_reset();
      end_sim();
   end
endmodule : testbench
bind tdf_debug_port tdf_debug_port_properties u_props (
   .clock_in                    (clock_in),
   .rst_in                      (rst_in),
   .debug_link_clock_line_in    (debug_link_clock_line_in),
   .debug_link_data_line_out    (debug_link_data_line_out),
   .debug_link_data_line_oe_out (debug_link_data_line_oe_out),
   .port_latch_in               (port_latch_in),
   .port_output_mode_bit_in     (port_output_mode_bit_in),
   .core_halt_out               (core_halt_out),
   .flash_valid_out             (flash_valid_out),
   .flash_ready_in              (flash_ready_in),
   .flash_byte_out              (flash_byte_out),
   .flash_first_out             (flash_first_out),
   .link_busy_out               (link_busy_out)
);
`default_nettype wire
